// *** src/pss_low_filter.sv ***
// Low pulse width classifier for the chip enable input
`timescale 1ns/10ps
module pss_low_filter
   import pss_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Enable input and widths
   input  wire logic             chip_enable_input,
   input  wire logic [CNT_W-1:0] reset_width,
   input  wire logic [CNT_W-1:0] pdown_width,
   // Classified events
   output logic                  low_reset,
   output logic                  low_pdown,
   output logic                  en_high
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             rst_done;
      logic             low_reset;
      logic             low_pdown;
      logic             en_high;
   } pss_flt_s;

   pss_flt_s st_ff;
   pss_flt_s nxt_st;

   // Measure low time; short glitches produce no event
   always_comb
   begin
      nxt_st           = st_ff;
      nxt_st.low_reset = 1'b0;
      nxt_st.low_pdown = 1'b0;
      if (chip_enable_input)
      begin
         nxt_st.cnt      = '0;
         nxt_st.rst_done = 1'b0;
         nxt_st.en_high  = (st_ff.cnt < CNT_W'(GLITCH_CYC)) ? 1'b1 : st_ff.en_high;
         if (st_ff.cnt >= CNT_W'(GLITCH_CYC))
            nxt_st.en_high = 1'b1;
      end
      else
      begin
         if (st_ff.cnt != '1)
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
         // Reset fires once the reset width is reached
         if (!st_ff.rst_done && st_ff.cnt == reset_width - CNT_W'(1))
         begin
            nxt_st.low_reset = 1'b1;
            nxt_st.rst_done  = 1'b1;
         end
         if (st_ff.cnt >= pdown_width - CNT_W'(1))
         begin
            nxt_st.low_pdown = 1'b1;
            nxt_st.en_high   = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign low_reset = st_ff.low_reset;
   assign low_pdown = st_ff.low_pdown;
   assign en_high   = st_ff.en_high;

endmodule

// *** src/pss_lpo_div.sv ***
// Divider producing the low power oscillator enable pulse
`timescale 1ns/10ps
module pss_lpo_div
   import pss_pkg::*;
#(
   parameter int DIV = pss_pkg::LPO_DIV
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic run,
   output logic      tick
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } pss_div_s;

   pss_div_s st_ff;
   pss_div_s nxt_st;

   // Count up, pulse once per period
   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.tick = 1'b0;
      if (!run)
      begin
         nxt_st.cnt = '0;
      end
      else if (st_ff.cnt == CNT_W'(DIV - 1))
      begin
         nxt_st.cnt  = '0;
         nxt_st.tick = 1'b1;
      end
      else
      begin
         nxt_st.cnt = st_ff.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign tick = st_ff.tick;

endmodule

// *** src/pss_pkg.sv ***
// Package for the power state sequencer: constants, states and carriers
// Summary of operation
// - Enable high boots, held low powers down
// - Ignore enable low pulses under 3.4 us
// - Longer low resets, longest low powers down
// - Interface select sampled only at boot
// - Ready for operation within 1 ms
// - Power-down tristates pins, ignores events
// - Power-down exit starts fully reset
// - Full power runs clocks, accepts host
// - Standby retains internal state
// - Standby wakes on host, poll, detect
// - Ramp-up and standby use low power oscillator
// - System clock from PLL on reference
// - Crystal oscillator targets 27.12 MHz crystal
package pss_pkg;

   // Clock rate
   localparam int CLK_PERIOD_PS      = 10000;

   // Enable glitch filter, least time rounds up
   localparam int GLITCH_NS_X10      = 34;
   localparam int GLITCH_CYC         = (GLITCH_NS_X10 * 100 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESET_CYC_DEF      = 2 * GLITCH_CYC;
   localparam int PDOWN_CYC_DEF      = 8 * GLITCH_CYC;

   // Boot ready time, longest time rounds down
   localparam int READY_US           = 1000;
   localparam int READY_CYC_DEF      = READY_US * 1000000 / CLK_PERIOD_PS;

   // Clock frequencies in kHz
   localparam int LPO_KHZ            = 125;
   localparam int SYS_KHZ            = 13560;
   localparam int XTAL_KHZ           = 27120;
   localparam int REF_MIN_KHZ        = 13150;
   localparam int REF_MAX_KHZ        = 52000;
   localparam int LPO_DIV            = 100000 / LPO_KHZ;

   localparam int CNT_W              = 20;
   localparam int SIF_W              = 2;
   localparam int GPIO_W             = 8;

   localparam logic [SIF_W-1:0] SIF_RST = 2'h0;

   typedef enum logic [2:0] {
      PSS_PDOWN,
      PSS_RAMP,
      PSS_FULL,
      PSS_STANDBY_STATE
   } pss_state_e;

   // Wake requests while in standby
   typedef struct packed {
      logic host;
      logic poll;
      logic card;
      logic field;
   } pss_wake_s;

   // Clock and supply controls toward the analog side
   typedef struct packed {
      logic lpo_sel;
      logic pll_en;
      logic xo_en;
      logic dom_en;
   } pss_clk_s;

endpackage

// *** src/pss_top.sv ***
// Power state sequencer: energy states, boot latch, clock selection
`timescale 1ns/10ps
module pss_top
   import pss_pkg::*;
#(
   parameter int RESET_CYC = pss_pkg::RESET_CYC_DEF,
   parameter int PDOWN_CYC = pss_pkg::PDOWN_CYC_DEF,
   parameter int READY_CYC = pss_pkg::READY_CYC_DEF
)
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // Host side pins
   input  wire logic                      chip_enable_input,
   input  wire logic                      pad_supply,
   input  wire logic [pss_pkg::SIF_W-1:0] interface_select_pins,
   // Internal requests
   input  wire logic                      sleep_req,
   input  wire pss_pkg::pss_wake_s        wake_in,
   input  wire logic [pss_pkg::GPIO_W-1:0] gpio_out,
   input  wire logic [pss_pkg::GPIO_W-1:0] gpio_oe,
   // State and controls
   output pss_pkg::pss_state_e            power_state,
   output pss_pkg::pss_clk_s              clk_ctrl,
   output logic                           core_rst_n,
   output logic                           host_if_en,
   output logic                           ready,
   output logic [pss_pkg::SIF_W-1:0]      host_if_sel,
   output logic                           sif_oe,
   output logic [pss_pkg::GPIO_W-1:0]     gpio_pin_out,
   output logic [pss_pkg::GPIO_W-1:0]     gpio_pin_oe,
   output logic                           lpo_tick
);

   typedef struct packed {
      pss_state_e       state;
      logic [CNT_W-1:0] rdy_cnt;
      logic [SIF_W-1:0] sif;
      logic             core_rst_n;
      logic             rst_hold;
      logic             ready;
      logic             host_en;
      logic             sif_oe;
      pss_clk_s         clk;
      logic [GPIO_W-1:0] gout;
      logic [GPIO_W-1:0] goe;
      logic             tick;
   } pss_top_s;

   pss_top_s st_ff;
   pss_top_s nxt_st;

   logic low_reset;
   logic low_pdown;
   logic en_high;
   logic div_tick;
   logic wake_any;

   // Widths kept as inputs to the filter so a variant can program them
   pss_low_filter u_flt
   (
      .clk               (clk),
      .rst_n             (rst_n),
      .chip_enable_input (chip_enable_input),
      .reset_width       (CNT_W'(RESET_CYC)),
      .pdown_width       (CNT_W'(PDOWN_CYC)),
      .low_reset         (low_reset),
      .low_pdown         (low_pdown),
      .en_high           (en_high)
   );

   // Low power oscillator tick runs whenever lpo_sel is set (ramp-up and standby)
   pss_lpo_div #(.DIV(LPO_DIV)) u_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (st_ff.clk.lpo_sel),
      .tick  (div_tick)
   );

   assign wake_any = wake_in.host | wake_in.poll | wake_in.card | wake_in.field;

   // State sequencing: every state sets each control it owns
   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.tick = div_tick & st_ff.clk.lpo_sel;
      case (st_ff.state)
         PSS_PDOWN:
         begin
            // Nothing external is answered here except the enable
            nxt_st.core_rst_n  = 1'b0;
            nxt_st.rst_hold    = 1'b0;
            nxt_st.ready       = 1'b0;
            nxt_st.host_en     = 1'b0;
            nxt_st.sif_oe      = 1'b0;
            nxt_st.goe         = '0;
            nxt_st.gout        = '0;
            nxt_st.rdy_cnt     = '0;
            nxt_st.clk.lpo_sel = 1'b0;
            nxt_st.clk.pll_en  = 1'b0;
            nxt_st.clk.xo_en   = 1'b0;
            nxt_st.clk.dom_en  = 1'b0;
            if (en_high && chip_enable_input)
            begin
               nxt_st.state       = PSS_RAMP;
               nxt_st.sif         = interface_select_pins;
               nxt_st.clk.lpo_sel = 1'b1;
               nxt_st.clk.pll_en  = 1'b1;
               nxt_st.clk.xo_en   = 1'b1;
               nxt_st.clk.dom_en  = 1'b1;
            end
         end
         PSS_RAMP:
         begin
            // Select pins stay inputs and gpio stays off until ready
            nxt_st.ready       = 1'b0;
            nxt_st.host_en     = 1'b0;
            nxt_st.sif_oe      = 1'b0;
            nxt_st.goe         = '0;
            nxt_st.gout        = '0;
            nxt_st.clk.lpo_sel = 1'b1;
            nxt_st.clk.pll_en  = 1'b1;
            nxt_st.clk.xo_en   = 1'b1;
            nxt_st.clk.dom_en  = 1'b1;
            // After a reset pulse the core waits for the enable to return;
            // short glitches never set the hold, so they cannot reset the core
            if (chip_enable_input)
               nxt_st.rst_hold = 1'b0;
            nxt_st.core_rst_n = !st_ff.rst_hold;
            // Boot time counts pad good cycles once the core is released
            if (pad_supply && !st_ff.rst_hold)
               nxt_st.rdy_cnt = st_ff.rdy_cnt + CNT_W'(1);
            if (st_ff.rdy_cnt >= CNT_W'(READY_CYC - 1))
            begin
               nxt_st.state       = PSS_FULL;
               nxt_st.ready       = 1'b1;
               nxt_st.host_en     = 1'b1;
               nxt_st.sif_oe      = 1'b1;
               nxt_st.core_rst_n  = 1'b1;
               nxt_st.clk.lpo_sel = 1'b0;
            end
         end
         PSS_FULL:
         begin
            // Everything runs; gpio follows the core
            nxt_st.core_rst_n  = 1'b1;
            nxt_st.ready       = 1'b1;
            nxt_st.host_en     = 1'b1;
            nxt_st.sif_oe      = 1'b1;
            nxt_st.gout        = gpio_out;
            nxt_st.goe         = gpio_oe;
            nxt_st.clk.lpo_sel = 1'b0;
            nxt_st.clk.pll_en  = 1'b1;
            nxt_st.clk.xo_en   = 1'b1;
            nxt_st.clk.dom_en  = 1'b1;
            // Wake wins over sleep so no pending request is lost
            if (sleep_req && !wake_any)
            begin
               nxt_st.state       = PSS_STANDBY_STATE;
               nxt_st.clk.lpo_sel = 1'b1;
               nxt_st.clk.pll_en  = 1'b0;
               nxt_st.clk.xo_en   = 1'b0;
            end
         end
         PSS_STANDBY_STATE:
         begin
            // Registers, boot latch and gpio levels are left untouched
            nxt_st.host_en     = 1'b1;
            nxt_st.clk.lpo_sel = 1'b1;
            nxt_st.clk.pll_en  = 1'b0;
            nxt_st.clk.xo_en   = 1'b0;
            nxt_st.clk.dom_en  = 1'b1;
            if (wake_any)
            begin
               nxt_st.state       = PSS_FULL;
               nxt_st.clk.lpo_sel = 1'b0;
               nxt_st.clk.pll_en  = 1'b1;
               nxt_st.clk.xo_en   = 1'b1;
            end
         end
         default:
         begin
            nxt_st.state = PSS_PDOWN;
         end
      endcase
      // Power-down events override every state, reset pulses every state but power down
      if (low_reset && st_ff.state != PSS_PDOWN)
      begin
         nxt_st.state       = PSS_RAMP;
         nxt_st.rdy_cnt     = '0;
         nxt_st.rst_hold    = 1'b1;
         nxt_st.ready       = 1'b0;
         nxt_st.host_en     = 1'b0;
         nxt_st.core_rst_n  = 1'b0;
         nxt_st.sif_oe      = 1'b0;
         nxt_st.goe         = '0;
         nxt_st.gout        = '0;
         nxt_st.clk.lpo_sel = 1'b1;
         nxt_st.clk.pll_en  = 1'b1;
         nxt_st.clk.xo_en   = 1'b1;
         nxt_st.clk.dom_en  = 1'b1;
      end
      if (low_pdown)
      begin
         nxt_st.state       = PSS_PDOWN;
         nxt_st.rdy_cnt     = '0;
         nxt_st.rst_hold    = 1'b0;
         nxt_st.core_rst_n  = 1'b0;
         nxt_st.ready       = 1'b0;
         nxt_st.host_en     = 1'b0;
         nxt_st.sif_oe      = 1'b0;
         nxt_st.goe         = '0;
         nxt_st.gout        = '0;
         nxt_st.clk.lpo_sel = 1'b0;
         nxt_st.clk.pll_en  = 1'b0;
         nxt_st.clk.xo_en   = 1'b0;
         nxt_st.clk.dom_en  = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff       <= '0;
         st_ff.state <= PSS_PDOWN;
         st_ff.sif   <= SIF_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign power_state  = st_ff.state;
   assign clk_ctrl     = st_ff.clk;
   assign core_rst_n   = st_ff.core_rst_n;
   assign host_if_en   = st_ff.host_en;
   assign ready        = st_ff.ready;
   assign host_if_sel  = st_ff.sif;
   assign sif_oe       = st_ff.sif_oe;
   assign gpio_pin_out = st_ff.gout;
   assign gpio_pin_oe  = st_ff.goe;
   assign lpo_tick     = st_ff.tick;

endmodule

// *** verification/pss_host_model.sv ***
// Host controller model driving enable, pad supply and select pins
`timescale 1ns/10ps
module pss_host_model
   import pss_pkg::*;
(
   // Clock
   input wire logic         clk,
   // Pins toward the device
   output logic             en,
   output logic [SIF_W-1:0] sif,
   output logic             pad
);
   // Reference clock the host supplies, kept inside the accepted band
   localparam int REF_KHZ = REF_MIN_KHZ + (REF_MAX_KHZ - REF_MIN_KHZ) / 2;

   // Everything off at power on
   initial
   begin
      en  = 1'b0;
      sif = 2'h0;
      pad = 1'b0;
   end

   // Pad and select settle before enable rises
   task automatic boot(input logic [SIF_W-1:0] s);
      @(posedge clk) #1;
      pad = 1'b1;
      sif = s;
      repeat (2) @(posedge clk);
      #1 en = 1'b1;
   endtask

   // Enable low for n cycles, left low; supply never drops first
   task automatic low(input int n);
      @(posedge clk) #1 en = 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
endmodule

// *** verification/pss_monitor.sv ***
// Port level assertions for the power state sequencer
`timescale 1ns/10ps
module pss_monitor
   import pss_pkg::*;
#(
   parameter int RESET_CYC = 680,
   parameter int PDOWN_CYC = 2720,
   parameter int READY_CYC = 100000
)
(
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    rst_n,
   // Inputs
   input wire logic                    chip_enable_input,
   input wire logic                    pad_supply,
   input wire logic                    sleep_req,
   input wire pss_pkg::pss_wake_s      wake_in,
   // Outputs
   input wire pss_pkg::pss_state_e     power_state,
   input wire pss_pkg::pss_clk_s       clk_ctrl,
   input wire logic                    core_rst_n,
   input wire logic                    host_if_en,
   input wire logic                    ready,
   input wire logic [SIF_W-1:0]        host_if_sel,
   input wire logic                    sif_oe,
   input wire logic [GPIO_W-1:0]       gpio_pin_oe
);
   logic [CNT_W-1:0] low_ff;
   logic [CNT_W-1:0] ramp_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Low run length and boot wait, counted here so bounds stay exact
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_ff  <= '0;
         ramp_ff <= '0;
      end
      else
      begin
         low_ff  <= chip_enable_input ? '0 : low_ff + 1'b1;
         ramp_ff <= (power_state == PSS_RAMP && chip_enable_input && pad_supply) ? ramp_ff + 1'b1 : '0;
      end
   end

   a_pdown_hiz: assert property (
      power_state == PSS_PDOWN && $past(power_state) == PSS_PDOWN |-> !sif_oe && gpio_pin_oe == '0 && !ready)
      else $error("pins driven in power down");
   a_full_active: assert property (
      power_state == PSS_FULL && $past(power_state) == PSS_FULL
      |-> host_if_en && ready && clk_ctrl.pll_en && clk_ctrl.dom_en)
      else $error("full power not active");
   a_standby_state_keep: assert property (
      power_state == PSS_STANDBY_STATE && $past(power_state) == PSS_STANDBY_STATE |-> clk_ctrl.lpo_sel && ready && host_if_en)
      else $error("standby lost state or clock");
   a_glitch_ignored: assert property (
      $rose(chip_enable_input) && low_ff < GLITCH_CYC && power_state == PSS_FULL
      |-> (power_state != PSS_RAMP && power_state != PSS_PDOWN && core_rst_n) [*4])
      else $error("short low pulse acted");
   a_low_reset: assert property (
      low_ff == RESET_CYC && power_state inside {PSS_FULL, PSS_STANDBY_STATE}
      |-> ##[1:4] power_state == PSS_RAMP && !core_rst_n)
      else $error("reset pulse not taken");
   a_low_pdown: assert property (
      low_ff == PDOWN_CYC |-> ##[1:4] power_state == PSS_PDOWN)
      else $error("long low did not power down");
   a_ready_bound: assert property (
      ramp_ff <= READY_CYC + 4)
      else $error("boot took too long");
   a_sel_hold: assert property (
      !$stable(host_if_sel) |-> power_state inside {PSS_RAMP, PSS_PDOWN})
      else $error("select changed after boot");
   a_standby_state_wake: assert property (
      power_state == PSS_STANDBY_STATE && wake_in != '0 && chip_enable_input |-> ##[1:2] power_state == PSS_FULL)
      else $error("wake ignored");
   a_sleep_go: assert property (
      power_state == PSS_FULL && sleep_req && wake_in == '0 && chip_enable_input
      |-> ##[1:2] power_state == PSS_STANDBY_STATE)
      else $error("sleep ignored");
   a_ramp_quiet: assert property (
      power_state == PSS_RAMP |-> !sif_oe && gpio_pin_oe == '0 && !ready && !host_if_en)
      else $error("pins driven during boot");
endmodule

// *** verification/tb.sv ***
// Self-checking testbench for the power state sequencer
`timescale 1ns/10ps
module tb;
   import pss_pkg::*;
   localparam int RC = 400;
   localparam int PC = 800;
   logic             clk, rst_n, en, pad, sleep_req, crst_n, hen, rdy, soe;
   logic [SIF_W-1:0] sif, sel, hsel;
   logic [GPIO_W-1:0] g_out, g_oe, p_out, p_oe;
   pss_wake_s        wake_in;
   pss_state_e       st;
   pss_clk_s         cc;
   int               mismatches, n_checks, cyc;
   logic             tick;
   int               n_tick, t0;

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   pss_host_model host (.clk(clk), .en(en), .sif(sif), .pad(pad));

   pss_top #(.RESET_CYC(RC), .PDOWN_CYC(PC), .READY_CYC(20)) dut (
      .clk(clk), .rst_n(rst_n), .chip_enable_input(en), .pad_supply(pad),
      .interface_select_pins(sif), .sleep_req(sleep_req), .wake_in(wake_in),
      .gpio_out(g_out), .gpio_oe(g_oe), .power_state(st), .clk_ctrl(cc),
      .core_rst_n(crst_n), .host_if_en(hen), .ready(rdy), .host_if_sel(hsel),
      .sif_oe(soe), .gpio_pin_out(p_out), .gpio_pin_oe(p_oe), .lpo_tick(tick));

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // Bounded wait for a state, sampled after the edge settles
   task wait_st(input pss_state_e s);
      for (int i = 0; i < 3000 && st !== s; i++)
         @(posedge clk) #1;
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Low power oscillator ticks seen by the bench
   always @(posedge clk)
   begin
      if (tick === 1'b1)
         n_tick++;
   end

   // Hang guard, far above the few thousand cycles needed
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         print_verdict;
      end
   end

   initial
   begin
      rst_n = 1'b0;
      sleep_req = 1'b0;
      wake_in = '0;
      g_out = '0;
      g_oe = '0;
      void'($urandom(32'h1b6b));
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("state", st, PSS_PDOWN);
      chk("sif_oe", soe, 0);
      sel = SIF_W'($urandom_range(3));
      host.boot(sel);
      wait_st(PSS_FULL);
      chk("state", st, PSS_FULL);
      chk("ready", rdy, 1);
      chk("sel", hsel, sel);
      chk("pll", cc.pll_en, 1);
      chk("host_en", hen, 1);
      $display("test boot done");
      // Select moved after boot, then gpio and a short glitch
      host.boot(~sel);
      g_out = GPIO_W'($urandom);
      g_oe = GPIO_W'($urandom) | 8'h01;
      repeat (4) @(posedge clk) #1;
      chk("sel", hsel, sel);
      chk("gpio", p_out, g_out);
      chk("gpio_oe", p_oe, g_oe);
      host.low($urandom_range(1, GLITCH_CYC - 10));
      host.boot(~sel);
      repeat (5) @(posedge clk) #1;
      chk("state", st, PSS_FULL);
      chk("core_rst", crst_n, 1);
      $display("test glitch done");
      // Standby woken by each source in turn
      for (int i = 0; i < 4; i++)
      begin
         sleep_req = 1'b1;
         wait_st(PSS_STANDBY_STATE);
         chk("state", st, PSS_STANDBY_STATE);
         chk("lpo", cc.lpo_sel, 1);
         sleep_req = 1'b0;
         if (i == 0)
         begin
            // Dwell in standby: one tick per divider period
            t0 = n_tick;
            repeat (2 * LPO_DIV + LPO_DIV / 2) @(posedge clk) #1;
            chk("lpo_tick", n_tick - t0, 2);
            chk("state", st, PSS_STANDBY_STATE);
         end
         wake_in = 4'h1 << i;
         wait_st(PSS_FULL);
         chk("state", st, PSS_FULL);
         wake_in = '0;
      end
      $display("test standby done");
      host.low(RC + 5);
      wait_st(PSS_RAMP);
      chk("state", st, PSS_RAMP);
      chk("core_rst", crst_n, 0);
      chk("sif_oe", soe, 0);
      chk("gpio_oe", p_oe, 0);
      host.boot(~sel);
      wait_st(PSS_FULL);
      chk("state", st, PSS_FULL);
      $display("test reset pulse done");
      // Power down ignores events, then a fresh boot
      host.low(PC + 5);
      wake_in = '1;
      sleep_req = 1'b1;
      repeat (20) @(posedge clk) #1;
      chk("state", st, PSS_PDOWN);
      chk("host_en", hen, 0);
      chk("gpio_oe", p_oe, 0);
      chk("sif_oe", soe, 0);
      wake_in = '0;
      sleep_req = 1'b0;
      sel = sel + 2'h1;
      host.boot(sel);
      wait_st(PSS_RAMP);
      chk("core_rst", crst_n, 0);
      wait_st(PSS_FULL);
      chk("sel", hsel, sel);
      $display("test power down done");
      print_verdict;
   end
endmodule

bind pss_top pss_monitor #(.RESET_CYC(RESET_CYC), .PDOWN_CYC(PDOWN_CYC), .READY_CYC(READY_CYC)) mon (
   .clk(clk), .rst_n(rst_n), .chip_enable_input(chip_enable_input), .pad_supply(pad_supply),
   .sleep_req(sleep_req), .wake_in(wake_in), .power_state(power_state), .clk_ctrl(clk_ctrl),
   .core_rst_n(core_rst_n), .host_if_en(host_if_en), .ready(ready), .host_if_sel(host_if_sel),
   .sif_oe(sif_oe), .gpio_pin_oe(gpio_pin_oe));
